/* File: rtl/fat_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - timeout code 0..3: fast acquire for code 1 only; pin hi-Z, low, low, high
// - code 4 or more runs timeout for code times two detector cycles
// - code 1 keeps fast acquire on forever, pin driven low
// - while counting pin grounded and fast pump current used, else hi-Z
// - fast acquire uses fast resistor codes, steady state uses normal
// - fast current code n gives n+1 times the base step
// - each of seven enable bits powers its block when set
// - writing register reset 1 restores defaults and powers part down
// - after reset release all blocks stay off until host enables
// - capacitor code gives c3/c4 pairs, codes 6 and 7 like 2
// - fast resistor-a code 0..3 gives 10 to 40 kilohms
// - fast resistor-b code 0..3 gives 10 to 40 kilohms
// - normal resistor a and b codes decode to 10 to 40 kilohms
module fat_ctrl (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        pd_clk,
	output logic             fast_acquire_pin_out,
	output logic             fast_acquire_pin_oe,
	output logic             fast_pump_select,
	output logic [4:0]       fast_pump_current,
	output logic             pll_power_enable,
	output logic             osc_core_power_enable,
	output logic             ref_osc_power_enable,
	output logic             core_regulator_enable,
	output logic             synth_regulator_a_enable,
	output logic             synth_regulator_b_enable,
	output logic             logic_regulator_enable,
	output logic [7:0]       filter_c3_pf,
	output logic [7:0]       filter_c4_pf,
	output logic [5:0]       filter_res_a_kohm,
	output logic [5:0]       filter_res_b_kohm
);
	logic [23:0] timer_cfg;
	logic [23:0] power_cfg;
	logic [23:0] filter_cfg;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic        wr_hit;
	logic        wr_timer;
	logic        wr_retune;
	logic        reg_rst;
	logic [23:0] next_timer;
	logic [23:0] next_power;
	logic [23:0] next_filter;
	logic        pd_meta;
	logic        pd_sync;
	logic        pd_last;
	logic        pd_tick;
	logic [14:0] tmo_left;
	logic        restart;
	logic [13:0] acquire_timeout_count;
	logic        fast_on;
	logic [1:0]  res_a_code;
	logic [1:0]  res_b_code;
	fat_pkg::fat_state_type state;

	// merge write data by byte strobes
	function automatic logic [23:0] merge(
		input logic [23:0] old,
		input logic [31:0] wd,
		input logic [3:0]  st
	);
		logic [23:0] r;
		r = old;
		for (int i = 0; i < 3; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// resistor code to kilohms
	function automatic logic [5:0] res_kohm(input logic [1:0] c);
		return 6'((c + 6'h01) * fat_pkg::RES_STEP);
	endfunction

	assign acquire_timeout_count = timer_cfg[fat_pkg::TOC_LSB +: fat_pkg::TOC_W];

	// write channel: take address and data in either order
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit = aw_addr == fat_pkg::ADDR_TIMER
		|| aw_addr == fat_pkg::ADDR_POWER
		|| aw_addr == fat_pkg::ADDR_FILTER
		|| aw_addr == fat_pkg::ADDR_RETUNE;
	assign wr_timer = wr_go && aw_addr == fat_pkg::ADDR_TIMER;
	assign wr_retune = wr_go && aw_addr == fat_pkg::ADDR_RETUNE;
	assign reg_rst = power_cfg[fat_pkg::RRST_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end
	end

	// ready while the slot is empty
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// write response
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fat_pkg::RESP_OK;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? fat_pkg::RESP_OK : fat_pkg::RESP_ERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register file next values
	always_comb begin
		next_timer = timer_cfg;
		next_power = power_cfg;
		next_filter = filter_cfg;
		if (wr_go && aw_addr == fat_pkg::ADDR_POWER) begin
			next_power = merge(power_cfg, w_data, w_strb);
		end
		if (next_power[fat_pkg::RRST_BIT]) begin
			next_timer = fat_pkg::RST_TIMER;
			next_filter = fat_pkg::RST_FILTER;
			next_power = fat_pkg::RST_POWER | (24'h000001 << fat_pkg::RRST_BIT);
		end else if (wr_go) begin
			if (aw_addr == fat_pkg::ADDR_TIMER) begin
				next_timer = merge(timer_cfg, w_data, w_strb);
			end
			if (aw_addr == fat_pkg::ADDR_FILTER) begin
				next_filter = merge(filter_cfg, w_data, w_strb);
			end
		end
	end

	// registers reset to the powered-off defaults
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_cfg <= fat_pkg::RST_TIMER;
			power_cfg <= fat_pkg::RST_POWER;
			filter_cfg <= fat_pkg::RST_FILTER;
		end else begin
			timer_cfg <= next_timer;
			power_cfg <= next_power;
			filter_cfg <= next_filter;
		end
	end

	// read channel, one read at a time
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= fat_pkg::RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= fat_pkg::RESP_OK;
			unique case (s_axi_araddr)
				fat_pkg::ADDR_TIMER: s_axi_rdata <= {8'h00, timer_cfg};
				fat_pkg::ADDR_POWER: s_axi_rdata <= {8'h00, power_cfg};
				fat_pkg::ADDR_FILTER: s_axi_rdata <= {8'h00, filter_cfg};
				fat_pkg::ADDR_STATUS: s_axi_rdata <=
					{1'b0, tmo_left, 15'h0000, fast_on};
				fat_pkg::ADDR_RETUNE: s_axi_rdata <= 32'h00000000;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= fat_pkg::RESP_ERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// detector clock pin: two-stage sync then edge detect
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_meta <= 1'b0;
			pd_sync <= 1'b0;
			pd_last <= 1'b0;
		end else begin
			pd_meta <= pd_clk;
			pd_sync <= pd_meta;
			pd_last <= pd_sync;
		end
	end
	assign pd_tick = pd_sync && !pd_last;

	// timeout restarts on a new setting or a retune strobe
	assign restart = (wr_timer || wr_retune) && !reg_rst
		&& next_timer[fat_pkg::TOC_LSB +: fat_pkg::TOC_W] >= fat_pkg::TOC_MIN;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= fat_pkg::FAT_STEADY;
			tmo_left <= 15'h0000;
		end else if (restart) begin
			state <= fat_pkg::FAT_FAST;
			tmo_left <= {next_timer[fat_pkg::TOC_LSB +: fat_pkg::TOC_W], 1'b0};
		end else if (reg_rst || acquire_timeout_count < fat_pkg::TOC_MIN) begin
			state <= fat_pkg::FAT_STEADY;
			tmo_left <= 15'h0000;
		end else begin
			unique case (state)
				fat_pkg::FAT_STEADY: tmo_left <= 15'h0000;
				fat_pkg::FAT_FAST: begin
					if (pd_tick) begin
						tmo_left <= tmo_left - 15'h0001;
						if (tmo_left == 15'h0001) begin
							state <= fat_pkg::FAT_STEADY;
						end
					end
				end
			endcase
		end
	end

	// a static code other than 1 ends fast acquire at once, even before the state drops
	assign fast_on = acquire_timeout_count == fat_pkg::TOC_ALWAYS
		|| (state == fat_pkg::FAT_FAST && acquire_timeout_count >= fat_pkg::TOC_MIN);

	// pin drive by timeout code
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_acquire_pin_out <= 1'b0;
			fast_acquire_pin_oe <= 1'b0;
		end else begin
			fast_acquire_pin_out <= 1'b0;
			unique case (acquire_timeout_count)
				fat_pkg::TOC_HIZ: fast_acquire_pin_oe <= 1'b0;
				fat_pkg::TOC_ALWAYS: fast_acquire_pin_oe <= 1'b1;
				fat_pkg::TOC_LOW: fast_acquire_pin_oe <= 1'b1;
				fat_pkg::TOC_HIGH: begin
					fast_acquire_pin_oe <= 1'b1;
					fast_acquire_pin_out <= 1'b1;
				end
				default: fast_acquire_pin_oe <= fast_on;
			endcase
		end
	end

	// pump current selection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_pump_select <= 1'b0;
			fast_pump_current <= 5'h01;
		end else begin
			fast_pump_select <= fast_on;
			fast_pump_current <= 5'(timer_cfg[fat_pkg::FPC_LSB +: fat_pkg::FPC_W]) + 5'h01;
		end
	end

	// block power enables, forced off while reset held
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{logic_regulator_enable, synth_regulator_b_enable,
			 synth_regulator_a_enable, core_regulator_enable,
			 ref_osc_power_enable, osc_core_power_enable,
			 pll_power_enable} <= 7'h00;
		end else begin
			{logic_regulator_enable, synth_regulator_b_enable,
			 synth_regulator_a_enable, core_regulator_enable,
			 ref_osc_power_enable, osc_core_power_enable,
			 pll_power_enable} <= reg_rst ? 7'h00 : power_cfg[fat_pkg::EN_W-1:0];
		end
	end

	// resistor codes follow the acquire phase
	assign res_a_code = fast_on ? filter_cfg[fat_pkg::RAF_LSB +: 2]
		: filter_cfg[fat_pkg::RAN_LSB +: 2];
	assign res_b_code = fast_on ? filter_cfg[fat_pkg::RBF_LSB +: 2]
		: filter_cfg[fat_pkg::RBN_LSB +: 2];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			filter_res_a_kohm <= fat_pkg::RES_STEP;
			filter_res_b_kohm <= fat_pkg::RES_STEP;
		end else begin
			filter_res_a_kohm <= res_kohm(res_a_code);
			filter_res_b_kohm <= res_kohm(res_b_code);
		end
	end

	// capacitor pair decode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			filter_c3_pf <= fat_pkg::CAP_50;
			filter_c4_pf <= fat_pkg::CAP_50;
		end else begin
			unique case (filter_cfg[fat_pkg::CAP_LSB +: 3])
				3'h0: {filter_c3_pf, filter_c4_pf} <= {fat_pkg::CAP_50, fat_pkg::CAP_50};
				3'h1: {filter_c3_pf, filter_c4_pf} <= {fat_pkg::CAP_50, fat_pkg::CAP_100};
				3'h3: {filter_c3_pf, filter_c4_pf} <= {fat_pkg::CAP_100, fat_pkg::CAP_50};
				3'h4: {filter_c3_pf, filter_c4_pf} <= {fat_pkg::CAP_150, fat_pkg::CAP_50};
				3'h5: {filter_c3_pf, filter_c4_pf} <= {fat_pkg::CAP_100, fat_pkg::CAP_100};
				default: {filter_c3_pf, filter_c4_pf} <= {fat_pkg::CAP_50, fat_pkg::CAP_150};
			endcase
		end
	end
endmodule

/* File: rtl/fat_pkg.sv */
package fat_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_TIMER  = 8'h00;
	localparam logic [7:0] ADDR_POWER  = 8'h04;
	localparam logic [7:0] ADDR_FILTER = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_RETUNE = 8'h10;
	localparam int REG_W = 24;
	localparam logic [23:0] RST_TIMER  = 24'h000000;
	localparam logic [23:0] RST_POWER  = 24'h000000;
	localparam logic [23:0] RST_FILTER = 24'h000000;
	// timer config fields
	localparam int TOC_LSB = 0;
	localparam int TOC_W   = 14;
	localparam int FPC_LSB = 14;
	localparam int FPC_W   = 4;
	// timeout codes
	localparam logic [13:0] TOC_HIZ    = 14'h0000;
	localparam logic [13:0] TOC_ALWAYS = 14'h0001;
	localparam logic [13:0] TOC_LOW    = 14'h0002;
	localparam logic [13:0] TOC_HIGH   = 14'h0003;
	localparam logic [13:0] TOC_MIN    = 14'h0004;
	// power fields
	localparam int EN_W    = 7;
	localparam int RRST_BIT = 7;
	// filter fields
	localparam int CAP_LSB = 0;
	localparam int RAF_LSB = 3;
	localparam int RAN_LSB = 5;
	localparam int RBF_LSB = 7;
	localparam int RBN_LSB = 9;
	// status fields
	localparam int STS_CNT_LSB = 16;
	// resistor step in kilohms
	localparam logic [5:0] RES_STEP = 6'h0A;
	localparam logic [7:0] CAP_50  = 8'h32;
	localparam logic [7:0] CAP_100 = 8'h64;
	localparam logic [7:0] CAP_150 = 8'h96;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [0:0] {
		FAT_STEADY = 1'b0,
		FAT_FAST   = 1'b1
	} fat_state_type;
endpackage

/* File: test/fat_ctrl_monitor.sv */
`timescale 1ns/1ps
module fat_ctrl_monitor (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        fast_acquire_pin_out,
	input wire logic        fast_acquire_pin_oe,
	input wire logic        fast_pump_select,
	input wire logic [4:0]  fast_pump_current,
	input wire logic [7:0]  filter_c3_pf,
	input wire logic [7:0]  filter_c4_pf,
	input wire logic [5:0]  filter_res_a_kohm,
	input wire logic [5:0]  filter_res_b_kohm
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// pin and pump relations
	a_fast_pin_low: assert property (fast_pump_select |-> fast_acquire_pin_oe && !fast_acquire_pin_out)
		else $error("fast pump without grounded pin");
	a_pin_high_drv: assert property (fast_acquire_pin_out |-> fast_acquire_pin_oe)
		else $error("pin high while undriven");
	a_pump_range: assert property (fast_pump_current inside {[1:16]})
		else $error("pump multiplier out of range");
	// filter decode ranges
	a_res_steps: assert property ({filter_res_a_kohm, filter_res_b_kohm} inside {[0:4095]}
		&& filter_res_a_kohm inside {10, 20, 30, 40} && filter_res_b_kohm inside {10, 20, 30, 40})
		else $error("resistor value off step");
	a_cap_pairs: assert property ({filter_c3_pf, filter_c4_pf} inside
		{16'h3232, 16'h3264, 16'h3296, 16'h6432, 16'h9632, 16'h6464})
		else $error("capacitor pair illegal");
	// read answer comes the next cycle; bus answers stand until taken
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	c_fast: cover property ($rose(fast_pump_select));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind fat_ctrl fat_ctrl_monitor u_fat_ctrl_monitor (.core_clk, .rst_n, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.fast_acquire_pin_out, .fast_acquire_pin_oe, .fast_pump_select, .fast_pump_current,
	.filter_c3_pf, .filter_c4_pf, .filter_res_a_kohm, .filter_res_b_kohm);

/* File: test/fat_host.sv */
`timescale 1ns/1ps
module fat_host (
	input wire logic        core_clk,
	output logic [7:0]      s_axi_awaddr,
	output logic            s_axi_awvalid,
	input wire logic        s_axi_awready,
	output logic [31:0]     s_axi_wdata,
	output logic [3:0]      s_axi_wstrb,
	output logic            s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	output logic            s_axi_bready,
	output logic [7:0]      s_axi_araddr,
	output logic            s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	output logic            s_axi_rready
);
	// idle bus; each task raises its answer ready one edge after valid
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		s_axi_wstrb = 4'hF;
	end
	// write word, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b0;
		forever begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'b1; // response must stand meanwhile
		end
		r = s_axi_bresp;
	endtask
	// read word
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b0;
		forever begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1; // read data must stand meanwhile
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
endmodule

/* File: test/test_fat_ctrl.sv */
`timescale 1ns/1ps
module test_fat_ctrl;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pd_clk = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, filter_c3_pf, filter_c4_pf;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        fast_acquire_pin_out, fast_acquire_pin_oe, fast_pump_select;
	logic        pll_power_enable, osc_core_power_enable, ref_osc_power_enable, core_regulator_enable;
	logic        synth_regulator_a_enable, synth_regulator_b_enable, logic_regulator_enable;
	logic [4:0]  fast_pump_current;
	logic [5:0]  filter_res_a_kohm, filter_res_b_kohm;
	logic [6:0]  ens;
	logic [13:0] code;
	int          miscompares = 0;
	int          checks_done = 0;
	int          pd_cnt = 0;
	int          n0;
	integer      seed = 32'hE4B68CE2;
	assign ens = {logic_regulator_enable, synth_regulator_b_enable, synth_regulator_a_enable,
		core_regulator_enable, ref_osc_power_enable, osc_core_power_enable, pll_power_enable};
	// clocks, detector clock free of core phase
	always #2 core_clk = ~core_clk;
	always #19.3 pd_clk = ~pd_clk;
	always @(posedge pd_clk) pd_cnt++;
	fat_host u_fat_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	fat_ctrl u_fat_ctrl (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pd_clk, .fast_acquire_pin_out, .fast_acquire_pin_oe, .fast_pump_select,
		.fast_pump_current, .pll_power_enable, .osc_core_power_enable, .ref_osc_power_enable,
		.core_regulator_enable, .synth_regulator_a_enable, .synth_regulator_b_enable,
		.logic_regulator_enable, .filter_c3_pf, .filter_c4_pf, .filter_res_a_kohm, .filter_res_b_kohm);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic [15:0] exp_cap(input logic [2:0] c);
		case (c)
			3'h0: return 16'h3232;
			3'h1: return 16'h3264;
			3'h3: return 16'h6432;
			3'h4: return 16'h9632;
			3'h5: return 16'h6464;
			default: return 16'h3296;
		endcase
	endfunction
	function automatic logic [5:0] exp_res(input logic [1:0] c);
		return 6'h0A * ({4'h0, c} + 6'h01);
	endfunction
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		u_fat_host.wr(a, d, resp);
	endtask
	// let the written value reach the outputs
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	initial begin
		#40000;
		miscompares++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		settle();
		check(ens, 7'h00);
		check({filter_c3_pf, filter_c4_pf, filter_res_a_kohm, filter_res_b_kohm}, {16'h3232, exp_res(2'h0), exp_res(2'h0)});
		$display("test reset done");
		// start-up: reset, release, enable
		w(8'h08, 32'h000007FF);
		w(8'h04, 32'h00000080);
		settle();
		check({ens, filter_c3_pf, filter_c4_pf}, 23'h3232);
		w(8'h04, 32'h00000000);
		settle();
		check(ens, 7'h00);
		w(8'h04, 32'h0000007F);
		settle();
		check(ens, 7'h7F);
		for (int i = 0; i < 6; i++) begin
			v = $random(seed) & 32'h7F; // reset bit kept clear
			w(8'h04, v);
			settle();
			check(ens, v[6:0]);
		end
		$display("test power done");
		for (int i = 0; i < 8; i++) begin
			v = ($random(seed) & 32'h7F8) | i;
			w(8'h08, v);
			settle();
			check({filter_c3_pf, filter_c4_pf}, exp_cap(v[2:0]));
			check({filter_res_a_kohm, filter_res_b_kohm}, {exp_res(v[6:5]), exp_res(v[10:9])});
		end
		$display("test filter done");
		// fast a 40, normal a 20, fast b 30, normal b 10
		w(8'h08, 32'h00000139);
		for (int c = 0; c < 4; c++) begin
			v = ($random(seed) & 32'h3C000) | c;
			w(8'h00, v);
			settle();
			check({fast_acquire_pin_oe, fast_acquire_pin_out, fast_pump_select}, {c != 0, c == 3, c == 1});
			check(fast_pump_current, v[17:14] + 5'h01);
			check({filter_res_a_kohm, filter_res_b_kohm}, c == 1 ? {exp_res(2'h3), exp_res(2'h2)} :
				{exp_res(2'h1), exp_res(2'h0)});
		end
		$display("test static done");
		for (int k = 0; k < 3; k++) begin
			code = (k < 2) ? 14'h0004 + k[13:0] : 14'h0006 + 14'($random(seed) & 3);
			w(8'h00, {18'h0, code});
			n0 = pd_cnt;
			repeat (6) @(posedge core_clk);
			#1;
			check({fast_acquire_pin_oe, fast_acquire_pin_out, fast_pump_select}, 3'h5);
			check({filter_res_a_kohm, filter_res_b_kohm, fast_pump_current}, {exp_res(2'h3), exp_res(2'h2), 5'h01});
			u_fat_host.rd(8'h0C, rdat, resp);
			check({rdat[0], resp}, 3'h4);
			if (k == 2) begin
				repeat (3) @(posedge pd_clk);
				@(posedge core_clk);
				w(8'h10, 32'h0);
				n0 = pd_cnt;
			end
			for (int t = 0; t < 2000 && fast_pump_select === 1'b1; t++) @(posedge core_clk);
			check((pd_cnt - n0 >= 2 * code - 1) && (pd_cnt - n0 <= 2 * code + 1), 1'b1);
			settle();
			check({fast_acquire_pin_oe, fast_pump_select, filter_res_a_kohm}, {2'h0, exp_res(2'h1)});
		end
		$display("test timeout done");
		w(8'h20, 32'h0);
		check(resp, 2'h2);
		u_fat_host.rd(8'h20, rdat, resp);
		check({rdat[29:0], resp}, 32'h2);
		u_fat_host.rd(8'h08, rdat, resp);
		check({rdat[29:0], resp}, 32'h139 << 2);
		$display("test bus done");
		end_sim();
	end
endmodule
